// *** logic/esc_top.sv ***
// Purpose: Two seconds counters behind a three-wire serial port.
// Assumes: main_ok comes from a supply comparator; sclk and frame_en from the host.
// Notes: Counter state lives on ref_clk; the shifter lives on sclk.
`timescale 1ns/100ps
`include "esc_consts.svh"
// Overview of operation
// - Serial reads and writes are refused while main supply is below 1.25 times battery.
// - The free-running counter keeps counting on backup power while the port is unusable.
// - The tick output runs only while main supply is valid and the trim is nonzero.
// - The command byte holds both selects in bits 7 and 6, trim in 5 to 3, clears, then read.
// - Free select with read set shifts out the free-running counter and changes nothing.
// - Free select with read clear takes 32 bits into the free-running counter.
// - Powered select moves the powered-time counter in the direction the read flag picks.
// - No select with the free clear flag zeroes the free-running counter at command end.
// - No select with the powered clear flag zeroes the powered-time counter likewise.
// - Both selects with read clear load the trim from bits 5 to 3 and touch no counter.
// - Command and write bits are sampled on the rising serial clock edge.
// - Read bits are driven on the falling edge and released while the clock is high.
// - A zero trim stops the oscillator and so both counters.
module esc_top #(
  parameter int HALF_TICK_CYCLES = `ESC_HALF_TICK_CYCLES,
  parameter int TRIM_STEP_CYCLES = `ESC_TRIM_STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic main_ok,
  input wire logic sclk,
  input wire logic frame_en,
  input wire logic dq_i,
  output logic dq_o,
  output logic dq_oe_n,
  output logic one_hz_tick_output,
  output esc_pkg::esc_word_t free_count,
  output esc_pkg::esc_word_t powered_count,
  output logic [2:0] trim
);
  import esc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Link side.
  esc_cmd_s link_cmd;
  esc_word_t link_word;
  logic link_valid;
  logic link_done;
  logic link_drive;
  logic link_dq;
  logic port_ok_q, port_ok_d;
  esc_word_t snap_free_q, snap_free_d;
  esc_word_t snap_pow_q, snap_pow_d;

  esc_link u_link (
    .sclk(sclk),
    .frame_en(frame_en),
    .dq_i(dq_i),
    .port_ok(port_ok_q),
    .snap_free(snap_free_q),
    .snap_pow(snap_pow_q),
    .cmd_q(link_cmd),
    .cmd_valid_q(link_valid),
    .wr_word_q(link_word),
    .wr_done_q(link_done),
    .dq_o_q(link_dq),
    .drive_q(link_drive)
  );

  assign dq_o = link_dq;
  // The release while sclk is high must not wait for a reference edge.
  assign dq_oe_n = ~(link_drive & ~sclk);

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers; stage 0 feeds only stage 1.
  logic [2:0] cv_q, cv_d;
  logic [2:0] wd_q, wd_d;
  logic [1:0] fe_q, fe_d;
  logic [1:0] mo_q, mo_d;
  logic cmd_rise;
  logic wr_rise;
  logic frame_on;
  logic main_on;

  always_comb begin
    cv_d = {cv_q[1:0], link_valid};
    wd_d = {wd_q[1:0], link_done};
    fe_d = {fe_q[0], frame_en};
    mo_d = {mo_q[0], main_ok};
    cmd_rise = cv_q[1] & ~cv_q[2];
    wr_rise = wd_q[1] & ~wd_q[2];
    frame_on = fe_q[1];
    main_on = mo_q[1];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // Starting high keeps a flag left standing by an earlier frame from looking new.
      cv_q <= 3'h7;
      wd_q <= 3'h7;
      fe_q <= 2'h0;
      mo_q <= 2'h0;
    end else begin
      cv_q <= cv_d;
      wd_q <= wd_d;
      fe_q <= fe_d;
      mo_q <= mo_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator: a prescaler of half seconds whose reload the trim shifts.
  logic [23:0] pre_q, pre_d;
  logic phase_q, phase_d;
  logic tick;
  logic [2:0] trim_q, trim_d;
  logic [23:0] reload;
  logic osc_run;
  logic osc_out_q, osc_out_d;

  always_comb begin
    // Higher trim gives a shorter period and so a faster clock.
    reload = 24'(HALF_TICK_CYCLES + `ESC_TRIM_NOMINAL * TRIM_STEP_CYCLES -
      int'(trim_q) * TRIM_STEP_CYCLES - 1);
    osc_run = trim_q != 3'h0;
    pre_d = pre_q;
    phase_d = phase_q;
    tick = 1'b0;
    if (osc_run) begin
      if (pre_q == 24'h000000) begin
        pre_d = reload;
        phase_d = ~phase_q;
        tick = ~phase_q;
      end else begin
        pre_d = pre_q - 24'h000001;
      end
    end
    osc_out_d = phase_q & main_on & osc_run;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_q <= 24'h000000;
      phase_q <= 1'b0;
      osc_out_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      phase_q <= phase_d;
      osc_out_q <= osc_out_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counters, trim and command execution.
  esc_word_t free_q, free_d;
  esc_word_t pow_q, pow_d;
  esc_cmd_s hold_q, hold_d;
  logic sel_f, sel_p;

  always_comb begin
    hold_d = hold_q;
    trim_d = trim_q;
    free_d = free_q;
    pow_d = pow_q;
    sel_f = 1'b0;
    sel_p = 1'b0;
    if (tick) begin
      free_d = free_q + 32'h00000001;
      if (main_on) begin
        pow_d = pow_q + 32'h00000001;
      end
    end
    if (cmd_rise && main_on) begin
      hold_d = link_cmd;
      sel_f = link_cmd.select_free_running_counter;
      sel_p = link_cmd.select_powered_time_counter;
      // Only the fields that an action names are looked at.
      case ({sel_f, sel_p})
        2'h3: begin
          if (!link_cmd.rd) begin
            trim_d = {link_cmd.trim_bit_high, link_cmd.trim_bit_mid,
              link_cmd.trim_bit_low};
          end
        end
        2'h0: begin
          if (link_cmd.clear_free_running_flag) begin
            free_d = `ESC_CNT_RST;
          end
          if (link_cmd.clear_powered_time_flag) begin
            pow_d = `ESC_CNT_RST;
          end
        end
        default: begin
          hold_d = link_cmd;
        end
      endcase
    end
    if (wr_rise && main_on) begin
      // The word lands whole, so a tick in the same cycle is overwritten.
      if (hold_q.select_free_running_counter && !hold_q.select_powered_time_counter) begin
        free_d = link_word;
      end else if (hold_q.select_powered_time_counter &&
        !hold_q.select_free_running_counter) begin
        pow_d = link_word;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_q <= esc_cmd_s'(8'h00);
      trim_q <= `ESC_TRIM_RST;
      free_q <= `ESC_CNT_RST;
      pow_q <= `ESC_CNT_RST;
    end else begin
      hold_q <= hold_d;
      trim_q <= trim_d;
      free_q <= free_d;
      pow_q <= pow_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read snapshots and the port gate.
  always_comb begin
    port_ok_d = main_on;
    // Snapshots freeze for the whole frame so the shifter sees a stable word.
    snap_free_d = frame_on ? snap_free_q : free_q;
    snap_pow_d = frame_on ? snap_pow_q : pow_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      snap_free_q <= `ESC_CNT_RST;
      snap_pow_q <= `ESC_CNT_RST;
      port_ok_q <= 1'b0;
    end else begin
      snap_free_q <= snap_free_d;
      snap_pow_q <= snap_pow_d;
      port_ok_q <= port_ok_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Visible state.
  assign one_hz_tick_output = osc_out_q;
  assign free_count = free_q;
  assign powered_count = pow_q;
  assign trim = trim_q;
endmodule

// *** logic/esc_consts.svh ***
// Purpose: Constants of the elapsed seconds counter port.
// Assumes: Reference clock of 10 MHz.
// Notes: Times are in ns; the half tick cycle count derives from them.
`ifndef ESC_CONSTS_SVH
`define ESC_CONSTS_SVH
`define ESC_REF_CLK_NS 100
`define ESC_HALF_TICK_NS 500000000
`define ESC_HALF_TICK_CYCLES (`ESC_HALF_TICK_NS / `ESC_REF_CLK_NS)
`define ESC_TRIM_STEP_CYCLES 100
`define ESC_TRIM_NOMINAL 3
`define ESC_TRIM_RST 3'h3
`define ESC_CMD_BITS 6'h08
`define ESC_FRAME_BITS 6'h28
`define ESC_CNT_RST 32'h00000000
`endif

// *** logic/esc_pkg.sv ***
// Purpose: Types shared by the seconds counter port.
// Assumes: Command bits arrive least significant first.
// Notes: The struct order matches the command byte, bit 7 first.
package esc_pkg;
  typedef struct packed {
    logic select_free_running_counter;
    logic select_powered_time_counter;
    logic trim_bit_high;
    logic trim_bit_mid;
    logic trim_bit_low;
    logic clear_free_running_flag;
    logic clear_powered_time_flag;
    logic rd;
  } esc_cmd_s;
  typedef logic [31:0] esc_word_t;
endpackage

// *** logic/esc_link.sv ***
// Purpose: Serial link end, clocked by the host's serial clock.
// Assumes: The serial clock runs only inside frames.
// Notes: A low frame enable clears the bit count at once; the done flags outlive the frame.
`timescale 1ns/100ps
`include "esc_consts.svh"
module esc_link (
  input wire logic sclk,
  input wire logic frame_en,
  input wire logic dq_i,
  input wire logic port_ok,
  input wire esc_pkg::esc_word_t snap_free,
  input wire esc_pkg::esc_word_t snap_pow,
  output esc_pkg::esc_cmd_s cmd_q,
  output logic cmd_valid_q,
  output esc_pkg::esc_word_t wr_word_q,
  output logic wr_done_q,
  output logic dq_o_q,
  output logic drive_q
);
  import esc_pkg::*;
  logic [5:0] cnt_q, cnt_d;
  logic [1:0] ok_q, ok_d;
  logic valid_d, done_d, drv_d;
  logic [7:0] sh_q, sh_d;
  esc_cmd_s cmd_d, new_cmd;
  esc_word_t wr_d, rd_q, rd_d;
  logic xfer;
  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    new_cmd = esc_cmd_s'({dq_i, sh_q[7:1]});
    xfer = cmd_q.select_free_running_counter ^ cmd_q.select_powered_time_counter;
    cnt_d = cnt_q;
    ok_d = {ok_q[0], port_ok};
    valid_d = cmd_valid_q;
    done_d = wr_done_q;
    sh_d = sh_q;
    cmd_d = cmd_q;
    wr_d = wr_word_q;
    rd_d = rd_q;
    // The flags drop at the first edge of a frame and then stand, however short it was.
    if (cnt_q == 6'h00) begin
      valid_d = 1'b0;
      done_d = 1'b0;
    end
    if (cnt_q != `ESC_FRAME_BITS) begin
      cnt_d = cnt_q + 6'h01;
    end
    if (cnt_q < `ESC_CMD_BITS) begin
      sh_d = new_cmd;
    end
    if (cnt_q == `ESC_CMD_BITS - 6'h01) begin
      cmd_d = new_cmd;
      valid_d = ok_q[1];
      rd_d = new_cmd.select_free_running_counter ? snap_free : snap_pow;
    end else if (cnt_q >= `ESC_CMD_BITS && cnt_q < `ESC_FRAME_BITS) begin
      rd_d = {1'b0, rd_q[31:1]};
      wr_d = {dq_i, wr_word_q[31:1]};
      if (cnt_q == `ESC_FRAME_BITS - 6'h01) begin
        done_d = cmd_valid_q & ~cmd_q.rd & xfer;
      end
    end
    drv_d = cmd_valid_q & cmd_q.rd & xfer & (cnt_q >= `ESC_CMD_BITS) &
      (cnt_q < `ESC_FRAME_BITS);
  end
  //////////////////////////////////////////////////////////////////////////////
  // The frame enable clears the bit count and ok_q so that a cut frame leaves no partial count.
  always_ff @(posedge sclk or negedge frame_en) begin
    if (!frame_en) begin
      cnt_q <= 6'h00;
      ok_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
      ok_q <= ok_d;
    end
  end
  // Data holds no reset so that the command stays stable after the frame.
  // The flags sit here too: a frame end that cleared them would cut a pulse too short to cross.
  always_ff @(posedge sclk) begin
    cmd_valid_q <= valid_d;
    wr_done_q <= done_d;
    sh_q <= sh_d;
    cmd_q <= cmd_d;
    wr_word_q <= wr_d;
    rd_q <= rd_d;
  end
  always_ff @(negedge sclk or negedge frame_en) begin
    if (!frame_en) begin
      drive_q <= 1'b0;
      dq_o_q <= 1'b0;
    end else begin
      drive_q <= drv_d;
      dq_o_q <= rd_q[0];
    end
  end
endmodule

// *** tb/esc_top_monitor.sv ***
// Purpose: Checker for the seconds counter port.
// Assumes: All properties sample on ref_clk.
// Notes: Repetition counts cover the main_ok and link flag synchroniser latencies.
`timescale 1ns/100ps
module esc_top_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic main_ok,
  input wire logic sclk,
  input wire logic frame_en,
  input wire logic dq_oe_n,
  input wire logic one_hz_tick_output,
  input wire esc_pkg::esc_word_t free_count,
  input wire esc_pkg::esc_word_t powered_count,
  input wire logic [2:0] trim
);
  import esc_pkg::*;
  logic refuse_d, refuse_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Armed only when supply fails between frames; a running frame may finish.
  always_comb refuse_d = !main_ok && (refuse_q || !frame_en);
  always_ff @(posedge ref_clk) refuse_q <= rst ? 1'b0 : refuse_d;
  sequence s_idle; (!frame_en)[*8]; endsequence
  sequence s_free_moved; free_count != $past(free_count); endsequence
  property p_rst_vals; $fell(rst) |-> trim == 3'h3 && free_count == 32'h0; endproperty
  property p_tick_trim; trim == 3'h0 && $past(trim, 2) == 3'h0 |-> !one_hz_tick_output; endproperty
  property p_tick_main; (!main_ok)[*5] |-> !one_hz_tick_output; endproperty
  property p_stop; (!frame_en && trim == 3'h0)[*8] |-> $stable(free_count); endproperty
  property p_pow_gate; (!main_ok && !frame_en)[*8] |-> $stable(powered_count); endproperty
  property p_free_step; s_idle ##0 s_free_moved |-> free_count == $past(free_count) + 32'h1;
  endproperty
  property p_hz_high; sclk |-> dq_oe_n; endproperty
  property p_hz_idle; !frame_en |-> dq_oe_n; endproperty
  property p_refuse; refuse_q |-> dq_oe_n; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  a_tick_trim: assert property (p_tick_trim) else $error("tick with zero trim");
  a_tick_main: assert property (p_tick_main) else $error("tick without supply");
  a_stop: assert property (p_stop) else $error("counter moved with zero trim");
  a_pow_gate: assert property (p_pow_gate) else $error("powered counter moved");
  a_free_step: assert property (p_free_step) else $error("free counter jumped");
  a_hz_high: assert property (p_hz_high) else $error("driven while clock high");
  a_hz_idle: assert property (p_hz_idle) else $error("driven outside frame");
  a_refuse: assert property (p_refuse) else $error("driven while refused");
endmodule
bind esc_top esc_top_monitor mon_u (.ref_clk, .rst, .main_ok, .sclk, .frame_en, .dq_oe_n,
  .one_hz_tick_output, .free_count, .powered_count, .trim);

// *** tb/esc_host.sv ***
// Purpose: Host end of the three-wire link.
// Assumes: Link clock of 80 ns, only inside frames.
// Notes: Frames end with the clock high.
`timescale 1ns/100ps
module esc_host (
  input wire logic ref_clk,
  input wire logic dq_o,
  input wire logic dq_oe_n,
  output logic sclk,
  output logic frame_en,
  output logic dq_i
);
  logic dq_h;
  // No pull on the pin, so a released line shows the inverse of its last level.
  assign dq_i = dq_oe_n ? dq_h : dq_o;
  initial begin
    sclk = 1'b0;
    frame_en = 1'b0;
    dq_h = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic frame(input logic [7:0] cmd, input logic [31:0] wr, input int n,
                       output logic [31:0] rd);
    logic [39:0] bits;
    bits = {wr, cmd};
    rd = 32'h0;
    @(posedge ref_clk);
    #1 frame_en = 1'b1;
    #100;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      dq_h = (cmd[0] && i >= 8) ? ~dq_i : bits[i];
      #40 if (i >= 8) rd[i - 8] = dq_i;
      sclk = 1'b1;
      #40;
    end
    frame_en = 1'b0;
    #100 sclk = 1'b0;
    #1000;
  endtask
endmodule

// *** tb/elapsed_seconds_counter_port_test.sv ***
// Purpose: Self-checking bench for the seconds counter port.
// Assumes: Short tick parameters keep the run brief.
// Notes: Results are read a fixed settle time after each frame.
`timescale 1ns/100ps
module elapsed_seconds_counter_port_test;
  import esc_pkg::*;
  logic ref_clk, rst, main_ok, sclk, frame_en, dq_i, dq_o, dq_oe_n, one_hz_tick_output;
  logic [2:0] trim;
  esc_word_t free_count, powered_count, rd, snap, snap_p;
  logic [1:0] seen;
  int fail_count, checks, cycles;
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  esc_top #(.HALF_TICK_CYCLES(20), .TRIM_STEP_CYCLES(1)) dut_u (.ref_clk, .rst, .main_ok,
    .sclk, .frame_en, .dq_i, .dq_o, .dq_oe_n, .one_hz_tick_output, .free_count,
    .powered_count, .trim);
  esc_host host_u (.ref_clk, .dq_o, .dq_oe_n, .sclk, .frame_en, .dq_i);
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Bit 1 tells that the tick was seen high, bit 0 that it was seen low, over 50 cycles, a period and a quarter at the reset trim.
  task automatic tick_seen(output logic [1:0] seen_o);
    seen_o = 2'h0;
    repeat (50) begin
      @(posedge ref_clk);
      #1;
      seen_o = seen_o | {one_hz_tick_output, ~one_hz_tick_output};
    end
  endtask
  // Effects land on the third reference edge after the last serial edge; 8 leaves margin.
  task automatic xfer(input logic [7:0] cmd, input logic [31:0] wr, input int n);
    host_u.frame(cmd, wr, n, rd);
    wait_cyc(8);
  endtask
  task automatic finish_test();
    $display("Counts: checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    main_ok = 1'b1;
    wait_cyc(10);
    rst = 1'b0;
    wait_cyc(4);
    check("trim", {29'h0, trim}, 32'h3);
    tick_seen(seen);
    check("tick", {30'h0, seen}, 32'h3);
    wait_cyc(50);
    xfer(8'hEE, 32'h0, 8);
    check("trim", {29'h0, trim}, 32'h5);
    check("kept", {31'h0, free_count != 32'h0 && powered_count != 32'h0}, 32'h1);
    xfer(8'hC0, 32'h0, 8);
    snap = free_count;
    snap_p = powered_count;
    tick_seen(seen);
    check("stopped", free_count, snap);
    check("powered stopped", powered_count, snap_p);
    check("tick", {30'h0, seen}, 32'h1);
    $display("Test trim done");
    xfer(8'hBC, 32'hDEADBEEF, 40);
    check("free", free_count, 32'hDEADBEEF);
    check("trim", {29'h0, trim}, 32'h0);
    xfer(8'h40, 32'h0F0F1234, 40);
    check("powered", powered_count, 32'h0F0F1234);
    xfer(8'h81, 32'h0, 40);
    check("read free", rd, 32'hDEADBEEF);
    check("read kept", free_count, 32'hDEADBEEF);
    xfer(8'h43, 32'h0, 40);
    check("read powered", rd, 32'h0F0F1234);
    xfer(8'h80, 32'h1, 20);
    check("short write", free_count, 32'hDEADBEEF);
    $display("Test transfer done");
    xfer(8'h3C, 32'h0, 8);
    check("free clear", free_count, 32'h0);
    check("powered kept", powered_count, 32'h0F0F1234);
    xfer(8'h80, 32'h00001234, 40);
    xfer(8'h06, 32'h0, 8);
    check("both clear free", free_count, 32'h0);
    check("both clear", powered_count, 32'h0);
    $display("Test clear done");
    xfer(8'hD8, 32'h0, 8);
    main_ok = 1'b0;
    wait_cyc(10);
    snap = free_count;
    snap_p = powered_count;
    xfer(8'h80, 32'h55, 40);
    xfer(8'h81, 32'h0, 40);
    tick_seen(seen);
    check("powered held", powered_count, snap_p);
    check("free runs", {31'h0, free_count > snap && free_count != 32'h55}, 32'h1);
    check("tick", {30'h0, seen}, 32'h1);
    $display("Test supply done");
    finish_test();
  end
endmodule
